// File: inc/ctab_defines.svh
`ifndef CTAB_DEFINES_SVH
`define CTAB_DEFINES_SVH
// ==========================================================
// register offsets
`define CTAB_OFF_MODCTL 12'h000
`define CTAB_OFF_MODSTAT 12'h004
`define CTAB_OFF_ENHCTL 12'h008
`define CTAB_OFF_BSEL 12'h00C
`define CTAB_OFF_ASSOC0 12'h010
`define CTAB_OFF_ASSOC1 12'h014
`define CTAB_OFF_TXCTL 12'h040
`define CTAB_OFF_RXBUF 12'h100
`define CTAB_RX_STRIDE_LSB 5
`define CTAB_RX_WORD_CTL 3'h0
`define CTAB_RX_WORD_ID 3'h1
`define CTAB_RX_WORD_DLC 3'h2
`define CTAB_RX_WORD_D0 3'h3
`define CTAB_RX_WORD_D1 3'h4
// ==========================================================
// field positions
`define CTAB_ABORT_ALL_BIT 4
`define CTAB_TX_DONE_BIT 7
`define CTAB_TX_ABT_BIT 6
`define CTAB_TX_LARB_BIT 5
`define CTAB_TX_ERR_BIT 4
`define CTAB_TX_REQ_BIT 3
`define CTAB_TX_IE_BIT 2
`define CTAB_RX_FULL_BIT 7
`define CTAB_RX_IE_BIT 4
`define CTAB_RX_ROLL_BIT 3
`define CTAB_RX_RTR_BIT 8
`define CTAB_RX_HIT_LSB 9
`define CTAB_RX_EXT_BIT 31
`define CTAB_ENH_WM_BIT 2
`define CTAB_ENH_TS_BIT 3
`define CTAB_STAT_WM_BIT 8
// ==========================================================
// values
`define CTAB_CODE_FIFO 5'h10
`define CTAB_CODE_NONE 5'h00
`define CTAB_WM_ONE 4'h1
`define CTAB_WM_FOUR 4'h4
`define CTAB_FIFO_MIN 4'h2
`define CTAB_N_TX 9
`define CTAB_N_DED_TX 3
`define CTAB_N_RX 8
`define CTAB_N_PROG 6
`define CTAB_N_FILT 16
`define CTAB_RESP_OKAY 2'h0
`define CTAB_RESP_SLVERR 2'h2
`endif

// File: inc/ctab_pkg.sv
package ctab_pkg;
	// ==========================================================
	// modes and frame carrier
	typedef enum logic [1:0] {
		CTAB_LEGACY = 2'h0,
		CTAB_ENH = 2'h1,
		CTAB_FIFO = 2'h2
	} ctab_mode_t;

	typedef struct packed {
		logic [28:0] id;
		logic ext;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
	} ctab_frame_t;

	typedef struct packed {
		logic load;
		logic [2:0] target;
		logic [4:0] hit;
	} ctab_rxsel_t;
endpackage : ctab_pkg

// File: hw/ctab_tx_arb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctab_defines.svh"
module ctab_tx_arb import ctab_pkg::*; (
	// candidates
	input wire logic [`CTAB_N_TX-1:0] ready,
	input wire logic [2*`CTAB_N_TX-1:0] prio,
	// winner
	output logic valid,
	output logic [3:0] idx
);
	// ==========================================================
	// priority pick, ties go to the higher buffer number
	always_comb begin
		logic [1:0] best;
		best = 2'h0;
		valid = 1'b0;
		idx = 4'h0;
		for (int i = 0; i < `CTAB_N_TX; i++) begin
			if (ready[i] && (!valid || prio[2*i +: 2] >= best)) begin // [R06] [R07] [R08]
				valid = 1'b1;
				best = prio[2*i +: 2];
				idx = 4'(i);
			end
		end
	end
endmodule : ctab_tx_arb
`default_nettype wire

// File: hw/ctab_rx_sel.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctab_defines.svh"
module ctab_rx_sel import ctab_pkg::*; (
	// configuration
	input wire ctab_mode_t mode,
	input wire logic [`CTAB_N_PROG-1:0] bsel,
	input wire logic [4*`CTAB_N_FILT-1:0] assoc,
	input wire logic [2*`CTAB_N_RX-1:0] receive_mode_field,
	input wire logic rollover,
	// buffer state
	input wire logic [`CTAB_N_RX-1:0] full,
	input wire logic [2:0] wr_ptr,
	// frame
	input wire logic [`CTAB_N_FILT-1:0] hits,
	input wire logic ext,
	input wire logic err,
	// result
	output ctab_rxsel_t sel,
	output logic [3:0] depth
);
	function automatic logic type_ok(input logic [1:0] m, input logic e);
		case (m)
			2'h1: type_ok = !e; // [R13]
			2'h2: type_ok = e; // [R13]
			default: type_ok = 1'b1;
		endcase
	endfunction : type_ok

	// ==========================================================
	// target buffer selection
	always_comb begin
		logic stop;
		logic acc0;
		logic acc1;
		logic drop;
		logic [`CTAB_N_RX-1:0] isrx;
		logic [`CTAB_N_RX-1:0] cand;
		stop = 1'b0;
		depth = `CTAB_FIFO_MIN;
		isrx = {~bsel, 2'h3};
		for (int k = 0; k < `CTAB_N_PROG; k++) begin
			if (!stop && !bsel[k]) depth = depth + 4'h1; // [R19]
			else stop = 1'b1;
		end
		sel = '0;
		drop = 1'b0;
		cand = '0;
		acc0 = (receive_mode_field[1:0] == 2'h3) ||
			(!err && |hits[1:0] && type_ok(receive_mode_field[1:0], ext)); // [R14] [R16]
		acc1 = (receive_mode_field[3:2] == 2'h3) ||
			(!err && |hits[5:2] && type_ok(receive_mode_field[3:2], ext)); // [R16]
		case (mode)
			CTAB_LEGACY: begin
				if (acc0 && !full[0]) begin
					sel.load = 1'b1;
					sel.hit = hits[0] ? 5'h00 : 5'h01;
				end else if (acc0 && rollover && !full[1]) begin // [R17]
					sel.load = 1'b1;
					sel.target = 3'h1;
					sel.hit = hits[0] ? 5'h00 : 5'h01;
				end else if (acc1 && !full[1]) begin
					sel.load = 1'b1;
					sel.target = 3'h1;
					for (int f = 5; f >= 2; f--) begin
						if (hits[f]) sel.hit = 5'(f); // [R11]
					end
				end
			end
			CTAB_ENH: begin
				for (int f = 0; f < `CTAB_N_FILT; f++) begin
					if (hits[f] && !assoc[4*f+3]) begin
						if (!isrx[assoc[4*f +: 3]]) drop = 1'b1; // [R15]
						else if (!err) cand[assoc[4*f +: 3]] = 1'b1;
					end
				end
				for (int b = 0; b < `CTAB_N_RX; b++) begin
					if (isrx[b] && receive_mode_field[2*b+1]) cand[b] = 1'b1; // [R14]
				end
				cand = cand & ~full;
				for (int b = `CTAB_N_RX-1; b >= 0; b--) begin
					if (cand[b]) sel.target = 3'(b); // [R18]
				end
				sel.load = |cand && !drop;
				for (int f = `CTAB_N_FILT-1; f >= 0; f--) begin
					if (hits[f] && assoc[4*f +: 4] == {1'b0, sel.target}) begin
						sel.hit = 5'(f); // [R11]
					end
				end
			end
			CTAB_FIFO: begin
				for (int f = `CTAB_N_FILT-1; f >= 0; f--) begin
					if (hits[f] && !assoc[4*f+3]) begin
						if (!isrx[assoc[4*f +: 3]]) drop = 1'b1; // [R15]
						else if (!err && 4'(assoc[4*f +: 3]) < depth) begin
							cand[0] = 1'b1;
							sel.hit = 5'(f);
						end
					end
				end
				sel.target = wr_ptr; // [R19]
				sel.load = (cand[0] || receive_mode_field[1]) && !drop && !full[wr_ptr];
			end
			default: sel = '0;
		endcase
	end
endmodule : ctab_rx_sel
`default_nettype wire

// File: hw/ctab_core.sv
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ctab_defines.svh"
// Overview of operation
// [R01] firmware clearing a buffer's transmit request (bit 3) requests its abort
// [R02] setting abort-all (bit 4) requests abort of every pending buffer
// [R03] abort taken if not started, or lost arbitration/error; aborted flag bit 6
// [R04] a frame in flight finishes; success leaves aborted clear, failure aborts
// [R05] abort requests cannot be cancelled by firmware; only hardware or reset
// [R06] before start of frame, highest transmit priority buffer is chosen
// [R07] equal priorities: highest buffer number goes first
// [R08] two-bit priority, 11 highest, 00 lowest
// [R09] accepted frame overwrites the whole target receive buffer
// [R10] load sets full flag; full buffer takes nothing until firmware clears
// [R11] filter hit recorded, four bits legacy, five bits enhanced; plus RTR flag
// [R12] extended-id flag in id word: clear standard, set extended
// [R13] legacy receive mode 00 filters, 01 standard only, 10 extended only
// [R14] mode 11 or upper bit takes all frames, errored ones partially
// [R15] enhanced modes discard frames hitting filters tied to transmit buffers
// [R16] legacy: buffer zero two filters higher priority, buffer one four
// [R17] rollover: full buffer zero sends frame to buffer one, no overflow
// [R18] enhanced: any filter to any buffer, lowest numbered buffer wins
// [R19] fifo mode: contiguous receive buffers, depth 2 to 8, write pointer
// [R20] fifo reception loads interrupt code 10000
// [R21] read pointer names oldest unread; clearing its full flag advances it
// [R22] water mark warns at one or four empty fifo slots
// [R23] setting transmit request clears aborted, arbitration lost, error flags
// [R24] success clears request, sets done flag, interrupt if enabled
// [R25] abort-all clears once no transmission remains pending
module ctab_core import ctab_pkg::*; (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// axi4-lite write
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// transmit engine
	output logic TX_PEND,
	output logic [3:0] TX_BUF,
	input wire logic TX_SOF,
	input wire logic TX_OK,
	input wire logic TX_LOST,
	input wire logic TX_ERR,
	// receive engine
	input wire logic RX_VALID,
	input wire logic RX_ERROR,
	input wire ctab_frame_t RX_FRAME,
	input wire logic [`CTAB_N_FILT-1:0] RX_HITS,
	// events
	output logic IRQ,
	output logic FIFO_WM,
	output logic TS_CAPTURE
);
	localparam int NT = `CTAB_N_TX;
	localparam int NR = `CTAB_N_RX;

	// ==========================================================
	// state
	logic bv_q, bv_d, rv_q, rv_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic abort_all_q, abort_all_d;
	ctab_mode_t mode_q, mode_d;
	logic wm_sel_q, wm_sel_d, ts_sel_q, ts_sel_d;
	logic [`CTAB_N_PROG-1:0] bsel_q, bsel_d;
	logic [4*`CTAB_N_FILT-1:0] assoc_q, assoc_d;
	logic [4:0] code_q, code_d;
	logic [NT-1:0] transmit_request_flag_q, transmit_request_flag_d, abt_q, abt_d, larb_q, larb_d;
	logic [NT-1:0] terr_q, terr_d, tdone_q, tdone_d, tie_q, tie_d;
	logic [NT-1:0] abreq_q, abreq_d;
	logic [2*NT-1:0] prio_q, prio_d;
	logic busy_q, busy_d;
	logic [3:0] act_q, act_d, txbuf_q, txbuf_d;
	logic txpend_q, txpend_d;
	logic [NR-1:0] full_q, full_d, rie_q, rie_d;
	logic [2*NR-1:0] rxm_q, rxm_d;
	logic roll_q, roll_d;
	logic [4:0] hit_q [NR], hit_d [NR];
	ctab_frame_t buf_q [NR], buf_d [NR];
	logic [2:0] wp_q, wp_d, rp_q, rp_d;
	logic [3:0] cnt_q, cnt_d;
	logic wm_q, wm_d, ts_q, ts_d, irq_q, irq_d;

	logic wr_go, rd_go;
	logic arb_valid;
	logic [3:0] arb_idx, depth;
	logic [NT-1:0] arb_ready, exists;
	ctab_rxsel_t rsel;

	assign exists = {bsel_q, 3'h7};

	// ==========================================================
	// helpers
	ctab_tx_arb u_arb (
		.ready(arb_ready),
		.prio(prio_q),
		.valid(arb_valid),
		.idx(arb_idx)
	);

	ctab_rx_sel u_sel (
		.mode(mode_q),
		.bsel(bsel_q),
		.assoc(assoc_q),
		.receive_mode_field(rxm_q),
		.rollover(roll_q),
		.full(full_q),
		.wr_ptr(wp_q),
		.hits(RX_HITS),
		.ext(RX_FRAME.ext),
		.err(RX_ERROR),
		.sel(rsel),
		.depth(depth)
	);

	function automatic logic [2:0] wrap(input logic [2:0] p,
			input logic [3:0] d);
		wrap = (4'(p) + 4'h1 >= d) ? 3'h0 : p + 3'h1;
	endfunction : wrap

	// ==========================================================
	// bus handshake
	assign wr_go = AWVALID && WVALID && !bv_q;
	assign rd_go = ARVALID && !rv_q;
	assign AWREADY = wr_go;
	assign WREADY = wr_go;
	assign ARREADY = rd_go;
	assign BVALID = bv_q;
	assign BRESP = bresp_q;
	assign RVALID = rv_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign TX_PEND = txpend_q;
	assign TX_BUF = txbuf_q;
	assign IRQ = irq_q;
	assign FIFO_WM = wm_q;
	assign TS_CAPTURE = ts_q;

	// ==========================================================
	// next state
	always_comb begin
		logic [11:0] a;
		logic [31:0] w;
		logic [2:0] rb;
		logic hit;
		logic abt_eff;
		logic [3:0] empty;
		bv_d = bv_q && !BREADY;
		bresp_d = bresp_q;
		rv_d = rv_q && !RREADY;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		abort_all_d = abort_all_q;
		mode_d = mode_q;
		wm_sel_d = wm_sel_q;
		ts_sel_d = ts_sel_q;
		bsel_d = bsel_q;
		assoc_d = assoc_q;
		code_d = code_q;
		transmit_request_flag_d = transmit_request_flag_q;
		abt_d = abt_q;
		larb_d = larb_q;
		terr_d = terr_q;
		tdone_d = tdone_q;
		tie_d = tie_q;
		abreq_d = abreq_q;
		prio_d = prio_q;
		busy_d = busy_q;
		act_d = act_q;
		full_d = full_q;
		rie_d = rie_q;
		rxm_d = rxm_q;
		roll_d = roll_q;
		hit_d = hit_q;
		buf_d = buf_q;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		ts_d = 1'b0;
		hit = 1'b0;
		abt_eff = 1'b0;
		empty = 4'h0;
		a = AWADDR;
		w = WDATA;
		rb = a[`CTAB_RX_STRIDE_LSB +: 3];
		// register writes
		if (wr_go) begin
			bv_d = 1'b1;
			bresp_d = `CTAB_RESP_OKAY;
			if (a == `CTAB_OFF_MODCTL) begin
				if (w[`CTAB_ABORT_ALL_BIT]) abort_all_d = 1'b1; // [R02] [R05]
			end else if (a == `CTAB_OFF_MODSTAT) begin
				code_d = `CTAB_CODE_NONE;
			end else if (a == `CTAB_OFF_ENHCTL) begin
				mode_d = ctab_mode_t'(w[1:0] == 2'h3 ? 2'h0 : w[1:0]);
				wm_sel_d = w[`CTAB_ENH_WM_BIT];
				ts_sel_d = w[`CTAB_ENH_TS_BIT];
			end else if (a == `CTAB_OFF_BSEL) begin
				bsel_d = w[`CTAB_N_PROG-1:0];
			end else if (a == `CTAB_OFF_ASSOC0) begin
				assoc_d[31:0] = w;
			end else if (a == `CTAB_OFF_ASSOC1) begin
				assoc_d[63:32] = w;
			end else if (a >= `CTAB_OFF_TXCTL &&
					a < `CTAB_OFF_TXCTL + 12'(4*NT) && a[1:0] == 2'h0) begin
				for (int i = 0; i < NT; i++) begin
					if (a[5:2] == 4'(i) && exists[i]) begin
						if (w[`CTAB_TX_REQ_BIT] && !transmit_request_flag_q[i] && !abreq_q[i]) begin
							transmit_request_flag_d[i] = 1'b1;
							abt_d[i] = 1'b0; // [R23]
							larb_d[i] = 1'b0; // [R23]
							terr_d[i] = 1'b0; // [R23]
						end
						if (!w[`CTAB_TX_REQ_BIT] && transmit_request_flag_q[i]) begin
							abreq_d[i] = 1'b1; // [R01] [R05]
						end
						if (!transmit_request_flag_q[i]) prio_d[2*i +: 2] = w[1:0];
						tie_d[i] = w[`CTAB_TX_IE_BIT];
						if (!w[`CTAB_TX_DONE_BIT]) tdone_d[i] = 1'b0;
					end
				end
			end else if (a >= `CTAB_OFF_RXBUF &&
					a < `CTAB_OFF_RXBUF + 12'(NR << `CTAB_RX_STRIDE_LSB) &&
					a[4:2] == `CTAB_RX_WORD_CTL && a[1:0] == 2'h0) begin
				rxm_d[2*rb +: 2] = w[6:5];
				rie_d[rb] = w[`CTAB_RX_IE_BIT];
				if (rb == 3'h0) roll_d = w[`CTAB_RX_ROLL_BIT];
				if (!w[`CTAB_RX_FULL_BIT] && full_q[rb]) begin
					full_d[rb] = 1'b0; // [R10]
					if (mode_q == CTAB_FIFO && rb == rp_q) begin
						rp_d = wrap(rp_q, depth); // [R21]
						cnt_d = cnt_d - 4'h1;
					end
				end
			end else begin
				bresp_d = `CTAB_RESP_SLVERR;
			end
		end
		// transmit engine events
		if (TX_SOF && txpend_q) begin
			busy_d = 1'b1;
			act_d = txbuf_q;
		end
		for (int i = 0; i < NT; i++) begin
			abt_eff = abreq_d[i] || abort_all_q;
			if (busy_q && act_q == 4'(i)) begin
				if (TX_OK) begin
					transmit_request_flag_d[i] = 1'b0; // [R24]
					tdone_d[i] = 1'b1; // [R24]
					abreq_d[i] = 1'b0; // [R04]
				end else if (TX_LOST || TX_ERR) begin
					larb_d[i] = larb_d[i] || TX_LOST;
					terr_d[i] = terr_d[i] || TX_ERR;
					if (abt_eff) begin
						transmit_request_flag_d[i] = 1'b0; // [R04]
						abt_d[i] = 1'b1; // [R03] [R04]
						abreq_d[i] = 1'b0;
					end
				end
			end else if (transmit_request_flag_q[i] && abt_eff) begin
				transmit_request_flag_d[i] = 1'b0; // [R03]
				abt_d[i] = 1'b1; // [R03]
				abreq_d[i] = 1'b0;
			end
		end
		if (TX_OK || TX_LOST || TX_ERR) busy_d = 1'b0;
		if (abort_all_q && transmit_request_flag_q == '0) abort_all_d = 1'b0; // [R25] [R05]
		// receive loads
		if (RX_VALID && rsel.load) begin
			buf_d[rsel.target] = RX_FRAME; // [R09] [R12]
			full_d[rsel.target] = 1'b1; // [R10]
			hit_d[rsel.target] = (mode_q == CTAB_LEGACY) ?
				{1'b0, rsel.hit[3:0]} : rsel.hit; // [R11]
			ts_d = ts_sel_q;
			if (mode_q == CTAB_FIFO) begin
				wp_d = wrap(wp_q, depth); // [R19]
				cnt_d = cnt_d + 4'h1;
				code_d = `CTAB_CODE_FIFO; // [R20]
			end
		end
		if (mode_q != CTAB_FIFO) begin
			wp_d = 3'h0;
			rp_d = 3'h0;
			cnt_d = 4'h0;
		end
		empty = depth - cnt_d;
		wm_d = mode_q == CTAB_FIFO &&
			empty == (wm_sel_q ? `CTAB_WM_FOUR : `CTAB_WM_ONE); // [R22]
		irq_d = |(tdone_d & tie_d) || |(full_d & rie_d) || wm_d; // [R10] [R24]
		// register reads
		if (rd_go) begin
			rv_d = 1'b1;
			rresp_d = `CTAB_RESP_OKAY;
			rdata_d = 32'h0;
			a = ARADDR;
			rb = a[`CTAB_RX_STRIDE_LSB +: 3];
			hit = 1'b1;
			if (a == `CTAB_OFF_MODCTL) begin
				rdata_d[`CTAB_ABORT_ALL_BIT] = abort_all_q;
				rdata_d[3:0] = {1'b0, rp_q}; // [R21]
			end else if (a == `CTAB_OFF_MODSTAT) begin
				rdata_d[4:0] = code_q;
				rdata_d[`CTAB_STAT_WM_BIT] = wm_q;
			end else if (a == `CTAB_OFF_ENHCTL) begin
				rdata_d[1:0] = mode_q;
				rdata_d[`CTAB_ENH_WM_BIT] = wm_sel_q;
				rdata_d[`CTAB_ENH_TS_BIT] = ts_sel_q;
			end else if (a == `CTAB_OFF_BSEL) begin
				rdata_d[`CTAB_N_PROG-1:0] = bsel_q;
			end else if (a == `CTAB_OFF_ASSOC0) begin
				rdata_d = assoc_q[31:0];
			end else if (a == `CTAB_OFF_ASSOC1) begin
				rdata_d = assoc_q[63:32];
			end else if (a >= `CTAB_OFF_TXCTL &&
					a < `CTAB_OFF_TXCTL + 12'(4*NT) && a[1:0] == 2'h0) begin
				for (int i = 0; i < NT; i++) begin
					if (a[5:2] == 4'(i)) begin
						rdata_d[`CTAB_TX_DONE_BIT] = tdone_q[i];
						rdata_d[`CTAB_TX_ABT_BIT] = abt_q[i];
						rdata_d[`CTAB_TX_LARB_BIT] = larb_q[i];
						rdata_d[`CTAB_TX_ERR_BIT] = terr_q[i];
						rdata_d[`CTAB_TX_REQ_BIT] = transmit_request_flag_q[i];
						rdata_d[`CTAB_TX_IE_BIT] = tie_q[i];
						rdata_d[1:0] = prio_q[2*i +: 2];
					end
				end
			end else if (a >= `CTAB_OFF_RXBUF &&
					a < `CTAB_OFF_RXBUF + 12'(NR << `CTAB_RX_STRIDE_LSB) &&
					a[1:0] == 2'h0) begin
				case (a[4:2])
					`CTAB_RX_WORD_CTL: begin
						rdata_d[`CTAB_RX_FULL_BIT] = full_q[rb];
						rdata_d[6:5] = rxm_q[2*rb +: 2];
						rdata_d[`CTAB_RX_IE_BIT] = rie_q[rb];
						rdata_d[`CTAB_RX_ROLL_BIT] = (rb == 3'h0) && roll_q;
						rdata_d[`CTAB_RX_RTR_BIT] = buf_q[rb].rtr; // [R11]
						rdata_d[`CTAB_RX_HIT_LSB +: 5] = hit_q[rb];
					end
					`CTAB_RX_WORD_ID: begin
						rdata_d[`CTAB_RX_EXT_BIT] = buf_q[rb].ext; // [R12]
						rdata_d[28:0] = buf_q[rb].id;
					end
					`CTAB_RX_WORD_DLC: rdata_d[3:0] = buf_q[rb].dlc;
					`CTAB_RX_WORD_D0: rdata_d = buf_q[rb].data[31:0];
					`CTAB_RX_WORD_D1: rdata_d = buf_q[rb].data[63:32];
					default: hit = 1'b0;
				endcase
			end else begin
				hit = 1'b0;
			end
			if (!hit) rresp_d = `CTAB_RESP_SLVERR;
		end
	end

	// ==========================================================
	// transmit candidate set
	always_comb begin
		for (int i = 0; i < NT; i++) begin
			arb_ready[i] = exists[i] && transmit_request_flag_q[i] && !abreq_q[i] &&
				!abort_all_q && !(busy_q && act_q == 4'(i));
		end
	end

	always_comb begin
		txpend_d = arb_valid && !busy_d; // [R06]
		txbuf_d = arb_idx;
	end

	// ==========================================================
	// registers
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			bv_q <= 1'b0;
			bresp_q <= `CTAB_RESP_OKAY;
			rv_q <= 1'b0;
			rresp_q <= `CTAB_RESP_OKAY;
			rdata_q <= 32'h0;
			abort_all_q <= 1'b0;
			mode_q <= CTAB_LEGACY;
			wm_sel_q <= 1'b0;
			ts_sel_q <= 1'b0;
			bsel_q <= '0;
			assoc_q <= '1;
			code_q <= `CTAB_CODE_NONE;
			transmit_request_flag_q <= '0;
			abt_q <= '0;
			larb_q <= '0;
			terr_q <= '0;
			tdone_q <= '0;
			tie_q <= '0;
			abreq_q <= '0;
			prio_q <= '0;
			busy_q <= 1'b0;
			act_q <= 4'h0;
			txbuf_q <= 4'h0;
			txpend_q <= 1'b0;
			full_q <= '0;
			rie_q <= '0;
			rxm_q <= '0;
			roll_q <= 1'b0;
			hit_q <= '{default: 5'h00};
			buf_q <= '{default: '0};
			wp_q <= 3'h0;
			rp_q <= 3'h0;
			cnt_q <= 4'h0;
			wm_q <= 1'b0;
			ts_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			bv_q <= bv_d;
			bresp_q <= bresp_d;
			rv_q <= rv_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			abort_all_q <= abort_all_d;
			mode_q <= mode_d;
			wm_sel_q <= wm_sel_d;
			ts_sel_q <= ts_sel_d;
			bsel_q <= bsel_d;
			assoc_q <= assoc_d;
			code_q <= code_d;
			transmit_request_flag_q <= transmit_request_flag_d;
			abt_q <= abt_d;
			larb_q <= larb_d;
			terr_q <= terr_d;
			tdone_q <= tdone_d;
			tie_q <= tie_d;
			abreq_q <= abreq_d;
			prio_q <= prio_d;
			busy_q <= busy_d;
			act_q <= act_d;
			txbuf_q <= txbuf_d;
			txpend_q <= txpend_d;
			full_q <= full_d;
			rie_q <= rie_d;
			rxm_q <= rxm_d;
			roll_q <= roll_d;
			hit_q <= hit_d;
			buf_q <= buf_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			wm_q <= wm_d;
			ts_q <= ts_d;
			irq_q <= irq_d;
		end
	end
endmodule : ctab_core
`default_nettype wire

// File: tb/ctab_core_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// port checks
module ctab_core_sva import ctab_pkg::*; (
	// clock and bus
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic AWVALID,
	input wire logic WVALID,
	input wire logic AWREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic RVALID,
	// engines and events
	input wire logic TX_PEND,
	input wire logic [3:0] TX_BUF,
	input wire logic TX_SOF,
	input wire logic RX_VALID,
	input wire logic TS_CAPTURE,
	input wire logic IRQ,
	input wire logic FIFO_WM
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	wr_answer_a: assert property (AWVALID && WVALID && !BVALID |=> BVALID)
		else $error("write not answered");
	rd_answer_a: assert property (ARVALID && !RVALID |=> RVALID)
		else $error("read not answered");
	resp_hold_a: assert property (BVALID && !BREADY |=> BVALID)
		else $error("write answer dropped");
	wr_gate_a: assert property (AWREADY |-> AWVALID && WVALID && !BVALID)
		else $error("write taken while busy");
	pend_drop_a: assert property (TX_PEND && TX_SOF |=> !TX_PEND)
		else $error("offer held after start");
	buf_range_a: assert property (TX_PEND |-> TX_BUF <= 4'h8)
		else $error("offered buffer out of range");
	ts_cause_a: assert property (
		TS_CAPTURE |-> $past(RX_VALID) || $past(RX_VALID, 2))
		else $error("capture without reception");
	wm_irq_a: assert property ($rose(FIFO_WM) |-> ##[0:1] IRQ)
		else $error("water mark without interrupt");
	cover property (TX_PEND && TX_SOF);
	cover property (TS_CAPTURE);
	cover property (FIFO_WM);
endmodule : ctab_core_sva
bind ctab_core ctab_core_sva u_sva (.*);
`default_nettype wire

// File: tb/ctab_eng_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// transmit engine on the far side
module ctab_eng_model import ctab_pkg::*; (
	// control
	input wire logic clk,
	input wire logic go,
	input wire logic [1:0] res,
	input wire logic pend,
	// engine strobes
	output logic sof,
	output logic ok,
	output logic lost,
	output logic err
);
	initial begin
		{sof, ok, lost, err} = 4'h0;
		forever begin
			@(posedge clk);
			if (go && pend) begin
				sof <= 1'b1;
				@(posedge clk);
				sof <= 1'b0;
				repeat (12 + $urandom % 6) @(posedge clk);
				{ok, lost, err} <= 3'h4 >> res;
				@(posedge clk);
				{ok, lost, err} <= 3'h0;
				repeat (2) @(posedge clk);
			end
		end
	end
endmodule : ctab_eng_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// bench
module tb import ctab_pkg::*;;
	logic SYS_CLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, go;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, idw;
	logic [3:0] WSTRB, TX_BUF;
	logic [1:0] BRESP, RRESP, res;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_PEND, TX_SOF, TX_OK;
	logic TX_LOST, TX_ERR, RX_VALID, RX_ERROR, IRQ, FIFO_WM, TS_CAPTURE;
	logic [15:0] RX_HITS;
	ctab_frame_t RX_FRAME, f;
	logic [75:0] q[$];
	logic [75:0] e;
	logic [3:0] tq[$];
	logic [2:0] evq[$];
	logic [127:0] r;
	int fails, n_compared;
	ctab_core dut (.*);
	ctab_eng_model eng (.clk(SYS_CLK), .go(go), .res(res), .pend(TX_PEND),
		.sof(TX_SOF), .ok(TX_OK), .lost(TX_LOST), .err(TX_ERR));
	initial begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do @(posedge SYS_CLK); while (AWREADY !== 1'b1);
		AWVALID <= 1'b0;
		WVALID <= 1'b0;
		do @(posedge SYS_CLK); while (BVALID !== 1'b1);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic [31:0] m);
		q.push_back({a, m, x});
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge SYS_CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge SYS_CLK); while (RVALID !== 1'b1);
	endtask : rd
	task automatic rx(input logic [15:0] h);
		r = {$urandom, $urandom, $urandom, $urandom};
		f = r[98:0];
		RX_FRAME <= f;
		RX_HITS <= h;
		RX_VALID <= 1'b1;
		@(posedge SYS_CLK);
		RX_VALID <= 1'b0;
		RX_FRAME <= ~f;
		RX_HITS <= ~h;
		repeat (3) @(posedge SYS_CLK);
	endtask : rx
	// ==========
	// result watcher
	always @(posedge SYS_CLK) begin
		if (RVALID === 1'b1) begin
			e = q.pop_front();
			chk($sformatf("reg %h", e[75:64]), e[31:0], RDATA & e[63:32]);
			chk("read resp", (e[75:64] == 12'hFFC) ? 32'h2 : 32'h0,
				{30'h0, RRESP});
		end
		if (BVALID === 1'b1)
			chk("write resp", 32'h0, {30'h0, BRESP});
		if (TX_SOF === 1'b1 && tq.size() > 0)
			chk("tx buffer", {27'h0, 1'b1, tq.pop_front()},
				{27'h0, TX_PEND, TX_BUF});
		if (TS_CAPTURE === 1'b1)
			chk("events", {29'h0, evq.pop_front()},
				{29'h0, IRQ, FIFO_WM, TS_CAPTURE});
	end
	initial begin
		repeat (5000) @(posedge SYS_CLK);
		fails++;
		report_and_stop();
	end
	// ==========
	// tests
	initial begin
		{SRST, AWVALID, WVALID, ARVALID, RX_VALID, RX_ERROR, go} = 7'h40;
		{AWADDR, ARADDR, WDATA, RX_HITS} = '0;
		RX_FRAME = '0;
		{WSTRB, BREADY, RREADY, res} = 8'hFC;
		void'($urandom(76154));
		repeat (5) @(posedge SYS_CLK);
		SRST <= 1'b0;
		@(posedge SYS_CLK);
		rd(12'h010, 32'hFFFFFFFF, 32'hFFFFFFFF);
		rd(12'h040, 32'h0, 32'hFF);
		rd(12'hFFC, 32'h0, 32'hFFFFFFFF);
		$display("reset values done");
		res <= 2'h0;
		wr(12'h040, 32'h0B);
		wr(12'h044, 32'h09);
		wr(12'h048, 32'h0B);
		tq = '{4'h2, 4'h0, 4'h1};
		go <= 1'b1;
		wait (tq.size() == 0);
		@(posedge SYS_CLK iff TX_OK === 1'b1);
		go <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		rd(12'h044, 32'h80, 32'hC8);
		$display("priority done");
		wr(12'h040, 32'h08);
		wr(12'h040, 32'h00);
		rd(12'h040, 32'h40, 32'h48);
		wr(12'h040, 32'h08);
		rd(12'h040, 32'h08, 32'h48);
		wr(12'h044, 32'h08);
		wr(12'h000, 32'h10);
		repeat (3) @(posedge SYS_CLK);
		rd(12'h040, 32'h40, 32'h48);
		rd(12'h044, 32'h40, 32'h48);
		rd(12'h000, 32'h0, 32'h10);
		$display("abort done");
		for (int i = 0; i < 2; i++) begin
			res <= i[1:0];
			go <= 1'b1;
			tq.push_back(4'h2);
			wr(12'h048, 32'h0B);
			@(posedge SYS_CLK iff TX_SOF === 1'b1);
			wr(12'h048, 32'h03);
			@(posedge SYS_CLK iff (TX_OK | TX_LOST) === 1'b1);
			go <= 1'b0;
			repeat (2) @(posedge SYS_CLK);
			rd(12'h048, (i != 0) ? 32'h40 : 32'h80, 32'hC8);
		end
		$display("abort in flight done");
		rx(16'h0002);
		idw = {f.ext, 2'h0, f.id};
		rd(12'h100, {18'h0, 5'h01, f.rtr, 8'h80}, 32'h3F80);
		rd(12'h104, idw, 32'hFFFFFFFF);
		rd(12'h10C, f.data[31:0], 32'hFFFFFFFF);
		rx(16'h0002);
		rd(12'h104, idw, 32'hFFFFFFFF);
		wr(12'h100, 32'h88);
		rx(16'h0002);
		rd(12'h120, {18'h0, 5'h01, f.rtr, 8'h80}, 32'h3F80);
		$display("receive done");
		wr(12'h100, 32'h0);
		wr(12'h010, 32'hFFFFFFF0);
		wr(12'h00C, 32'h01);
		wr(12'h008, 32'h0A);
		evq.push_back(3'h7);
		rx(16'h0001);
		rd(12'h004, 32'h110, 32'h11F);
		rd(12'h000, 32'h0, 32'hF);
		wr(12'h100, 32'h0);
		rd(12'h000, 32'h1, 32'hF);
		$display("fifo done");
		wr(12'h008, 32'h01);
		wr(12'h120, 32'h0);
		wr(12'h010, 32'hFFFFF120);
		rx(16'h0005);
		rd(12'h100, {18'h0, 5'h00, f.rtr, 8'h80}, 32'h3F80);
		rx(16'h0006);
		rd(12'h120, 32'h0, 32'h80);
		$display("enhanced done");
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
